//--- logic/xrs_cfg.svh
// constants of the transform record store: map, field positions, sizes
// assumes byte addressing on the register port, one word per 4 bytes
`ifndef XRS_CFG_SVH
`define XRS_CFG_SVH
`define XRS_NUM_SA 8
`define XRS_IDX_W 3
`define XRS_WORD_W 5
`define XRS_ADDR_W 12
`define XRS_REC_WORDS 5'h18
`define XRS_IGR_WORDS 5'h14
`define XRS_EGR_WORDS 5'h18
`define XRS_WIN_SEL_BIT 11
`define XRS_REC_HI 10
`define XRS_IDX_LSB 7
`define XRS_CTX_CTRL_ADDR 12'h800
`define XRS_STATUS_ADDR 12'h804
`define XRS_CTX_SIZE_BIT 0
`define XRS_ST_BUSY_BIT 0
`define XRS_ST_ROLL_BIT 1
`define XRS_ST_TYPE_BIT 2
`define XRS_TYPE_MSB 3
`define XRS_TYPE_EGR 4'h6
`define XRS_TYPE_IGR 4'hF
`define XRS_IV0_BIT 5
`define XRS_SEQ_128 5'h0A
`define XRS_SEQ_256 5'h0E
`define XRS_ACT_BYPASS 2'h0
`define XRS_ACT_DROP 2'h1
`define XRS_ACT_MACSEC 2'h2
`endif

//--- logic/xrs_pkg.sv
// types of the transform record store
// assumes xrs_cfg.svh is on the include path
`default_nettype none
`include "xrs_cfg.svh"
package xrs_pkg;
  typedef logic [31:0] xrs_word_t;
  typedef struct packed {
    logic valid;
    logic [`XRS_IDX_W-1:0] saIndex;
    logic [1:0] action;
    logic egress;
  } xrs_fetch_req_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic skipped;
    logic typeErr;
    logic ivMissing;
    logic [`XRS_WORD_W-1:0] wordIdx;
    xrs_word_t word;
  } xrs_fetch_rsp_t;
  typedef struct packed {
    logic valid;
    logic [`XRS_IDX_W-1:0] saIndex;
    logic egress;
    logic key256;
    logic extendedPacketNumbering;
    logic [63:0] rxPn;
  } xrs_seq_upd_t;
  typedef struct packed {
    logic hit;
    logic [`XRS_IDX_W-1:0] idx;
    logic [`XRS_WORD_W-1:0] word;
  } xrs_dec_t;
  typedef enum logic [1:0] {
    XRS_IDLE = 2'b01,
    XRS_FETCH = 2'b10
  } xrs_state_t;
endpackage
`default_nettype wire

//--- logic/xrs_record_store.sv
// transform record store: per-sa record array, register window, fetch and sequence write-back
// assumes the transform stage and register master run on sys_clk with synchronous srst
`default_nettype none
`include "xrs_cfg.svh"
module xrs_record_store
  import xrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`XRS_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire xrs_fetch_req_t fetchReq,
  output xrs_fetch_rsp_t fetchRsp,
  output logic fetchBusy,
  input wire xrs_seq_upd_t seqUpd,
  output logic seqError
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // window decode
  function automatic xrs_dec_t decode(input logic [`XRS_ADDR_W-1:0] a);
    xrs_dec_t d;
    d.idx = a[`XRS_REC_HI-1:`XRS_IDX_LSB];
    d.word = a[`XRS_IDX_LSB-1:2];
    d.hit = !a[`XRS_WIN_SEL_BIT] && !a[`XRS_REC_HI] && (a[1:0] == 2'h0) && (d.word < `XRS_REC_WORDS);
    return d;
  endfunction

  function automatic logic [`XRS_WORD_W-1:0] seqPos(input logic key256);
    return key256 ? `XRS_SEQ_256 : `XRS_SEQ_128;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  // record array
  xrs_word_t mem_r [`XRS_NUM_SA][`XRS_REC_WORDS];
  xrs_word_t mem_nxt [`XRS_NUM_SA][`XRS_REC_WORDS];
  logic ctxSize_r, ctxSize_nxt;
  logic rollSticky_r, rollSticky_nxt;
  logic typeSticky_r, typeSticky_nxt;
  logic [31:0] regRdData_r, regRdData_nxt;
  xrs_state_t state_r, state_nxt;
  logic [`XRS_IDX_W-1:0] fIdx_r, fIdx_nxt;
  logic fEgress_r, fEgress_nxt;
  logic [`XRS_WORD_W-1:0] fCnt_r, fCnt_nxt;
  logic [`XRS_WORD_W-1:0] fLimit_r, fLimit_nxt;
  xrs_fetch_rsp_t fetchRsp_r, fetchRsp_nxt;
  logic seqError_r, seqError_nxt;
  logic fetchBusy_r, fetchBusy_nxt;

  xrs_dec_t wDec;
  xrs_dec_t rDec;
  assign wDec = decode(regAddr);
  assign rDec = decode(regAddr);

  // ----------------------------------------
  // record array and sequence write-back
  // ----------------------------------------
  always_comb begin
    logic [`XRS_WORD_W-1:0] sp;
    logic [63:0] stored;
    logic [63:0] nextSeq;
    logic doUpd;
    logic roll;
    // sequence word follows key and hash words
    sp = seqPos(seqUpd.key256);
    stored = 64'h0;
    nextSeq = 64'h0;
    doUpd = 1'b0;
    roll = 1'b0;
    mem_nxt = mem_r;
    if (regWr && wDec.hit) begin
      mem_nxt[wDec.idx][wDec.word] = regWrData;
    end
    if (seqUpd.valid) begin
      // extended layout keeps the high half next to the low
      if (seqUpd.extendedPacketNumbering) begin
        stored = {mem_r[seqUpd.saIndex][sp + 5'h01], mem_r[seqUpd.saIndex][sp]};
      end else begin
        stored = {32'h0, mem_r[seqUpd.saIndex][sp]};
      end
      if (seqUpd.egress) begin
        roll = seqUpd.extendedPacketNumbering ? (stored == 64'hFFFFFFFFFFFFFFFF) : (stored[31:0] == 32'hFFFFFFFF);
        doUpd = !roll;
        nextSeq = stored + 64'h1;
      end else begin
        if (seqUpd.extendedPacketNumbering) begin
          doUpd = seqUpd.rxPn >= stored;
        end else begin
          doUpd = seqUpd.rxPn[31:0] >= stored[31:0];
        end
        nextSeq = seqUpd.rxPn + 64'h1;
      end
      if (doUpd) begin
        mem_nxt[seqUpd.saIndex][sp] = nextSeq[31:0];
        if (seqUpd.extendedPacketNumbering) begin
          mem_nxt[seqUpd.saIndex][sp + 5'h01] = nextSeq[63:32];
        end
      end
    end
    seqError_nxt = roll;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < `XRS_NUM_SA; i++) begin
        for (int j = 0; j < `XRS_REC_WORDS; j++) begin
          mem_r[i][j] <= 32'h0;
        end
      end
      seqError_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      seqError_r <= seqError_nxt;
    end
  end

  // ----------------------------------------
  // control and status registers
  // ----------------------------------------
  always_comb begin
    ctxSize_nxt = ctxSize_r;
    rollSticky_nxt = rollSticky_r;
    typeSticky_nxt = typeSticky_r;
    regRdData_nxt = 32'h0;
    if (regWr && regAddr == `XRS_CTX_CTRL_ADDR) begin
      ctxSize_nxt = regWrData[`XRS_CTX_SIZE_BIT];
    end
    if (regWr && regAddr == `XRS_STATUS_ADDR) begin
      if (regWrData[`XRS_ST_ROLL_BIT]) begin
        rollSticky_nxt = 1'b0;
      end
      if (regWrData[`XRS_ST_TYPE_BIT]) begin
        typeSticky_nxt = 1'b0;
      end
    end
    // set wins over clear
    // rollover and type sticky
    if (seqError_nxt) begin
      rollSticky_nxt = 1'b1;
    end
    if (fetchRsp_nxt.valid && fetchRsp_nxt.typeErr) begin
      typeSticky_nxt = 1'b1;
    end
    if (regRd) begin
      if (rDec.hit) begin
        regRdData_nxt = mem_r[rDec.idx][rDec.word];
      end else if (regAddr == `XRS_CTX_CTRL_ADDR) begin
        regRdData_nxt[`XRS_CTX_SIZE_BIT] = ctxSize_r;
      end else if (regAddr == `XRS_STATUS_ADDR) begin
        regRdData_nxt[`XRS_ST_BUSY_BIT] = fetchBusy_r;
        regRdData_nxt[`XRS_ST_ROLL_BIT] = rollSticky_r;
        regRdData_nxt[`XRS_ST_TYPE_BIT] = typeSticky_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctxSize_r <= 1'b0;
      rollSticky_r <= 1'b0;
      typeSticky_r <= 1'b0;
      regRdData_r <= 32'h0;
    end else begin
      ctxSize_r <= ctxSize_nxt;
      rollSticky_r <= rollSticky_nxt;
      typeSticky_r <= typeSticky_nxt;
      regRdData_r <= regRdData_nxt;
    end
  end

  // ----------------------------------------
  // context fetch
  // ----------------------------------------
  always_comb begin
    xrs_word_t w;
    logic [`XRS_TYPE_MSB:0] top;
    w = mem_r[fIdx_r][fCnt_r];
    top = w[`XRS_TYPE_MSB:0];
    state_nxt = state_r;
    fIdx_nxt = fIdx_r;
    fEgress_nxt = fEgress_r;
    fCnt_nxt = fCnt_r;
    fLimit_nxt = fLimit_r;
    fetchRsp_nxt = '0;
    fetchBusy_nxt = fetchBusy_r;
    unique case (state_r)
      XRS_IDLE: begin
        if (fetchReq.valid) begin
          // action plus record decide the transform
          if (fetchReq.action != `XRS_ACT_MACSEC) begin
            // no record access for bypass or drop
            fetchRsp_nxt.valid = 1'b1;
            fetchRsp_nxt.last = 1'b1;
            fetchRsp_nxt.skipped = 1'b1;
          end else begin
            state_nxt = XRS_FETCH;
            fIdx_nxt = fetchReq.saIndex;
            fEgress_nxt = fetchReq.egress;
            fCnt_nxt = '0;
            fetchBusy_nxt = 1'b1;
            if (ctxSize_r) begin
              fLimit_nxt = `XRS_REC_WORDS;
            end else begin
              fLimit_nxt = fetchReq.egress ? `XRS_EGR_WORDS : `XRS_IGR_WORDS;
            end
          end
        end
      end
      XRS_FETCH: begin
        fetchRsp_nxt.valid = 1'b1;
        fetchRsp_nxt.wordIdx = fCnt_r;
        fetchRsp_nxt.word = w;
        if (fCnt_r == '0) begin
          // bit 4 left out of the decode
          fetchRsp_nxt.typeErr = fEgress_r ? (top != `XRS_TYPE_EGR) : (top != `XRS_TYPE_IGR);
          fetchRsp_nxt.ivMissing = !w[`XRS_IV0_BIT];
        end
        fCnt_nxt = fCnt_r + 5'h01;
        if (fCnt_r == fLimit_r - 5'h01) begin
          fetchRsp_nxt.last = 1'b1;
          fCnt_nxt = '0;
          state_nxt = XRS_IDLE;
          fetchBusy_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= XRS_IDLE;
      fIdx_r <= '0;
      fEgress_r <= 1'b0;
      fCnt_r <= '0;
      fLimit_r <= `XRS_IGR_WORDS;
      fetchRsp_r <= '0;
      fetchBusy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fIdx_r <= fIdx_nxt;
      fEgress_r <= fEgress_nxt;
      fCnt_r <= fCnt_nxt;
      fLimit_r <= fLimit_nxt;
      fetchRsp_r <= fetchRsp_nxt;
      fetchBusy_r <= fetchBusy_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdData = regRdData_r;
  assign fetchRsp = fetchRsp_r;
  assign fetchBusy = fetchBusy_r;
  assign seqError = seqError_r;

endmodule
`default_nettype wire

//--- test/xrs_store_sva.sv
// checker on the ports of the transform record store
// assumes it is bound onto xrs_record_store from the bench
`default_nettype none
`include "xrs_cfg.svh"
module xrs_store_chk
  import xrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`XRS_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire xrs_fetch_req_t fetchReq,
  input wire xrs_fetch_rsp_t fetchRsp,
  input wire logic fetchBusy,
  input wire xrs_seq_upd_t seqUpd,
  input wire logic seqError
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctxSz_r;
  logic take;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  assign take = fetchReq.valid && !fetchBusy && fetchReq.action == `XRS_ACT_MACSEC;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctxSz_r <= 1'b0;
    end else if (regWr && regAddr == `XRS_CTX_CTRL_ADDR) begin
      ctxSz_r <= regWrData[`XRS_CTX_SIZE_BIT];
    end
  end
  a_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
    else $error("read data outside its slot");
  a_skip_flow: assert property (fetchReq.valid && !fetchBusy && fetchReq.action != `XRS_ACT_MACSEC
    |=> fetchRsp.valid && fetchRsp.skipped && fetchRsp.last)
    else $error("bypass or drop flow not skipped");
  a_full_fetch: assert property (take && (fetchReq.egress || ctxSz_r) |=> !fetchRsp.valid
    ##1 fetchRsp.valid && fetchRsp.wordIdx == 5'h00
    ##23 fetchRsp.last && fetchRsp.wordIdx == 5'h17 && !fetchBusy)
    else $error("full fetch length wrong");
  a_short_fetch: assert property (take && !fetchReq.egress && !ctxSz_r |=> !fetchRsp.valid
    ##1 fetchRsp.valid && fetchRsp.wordIdx == 5'h00
    ##19 fetchRsp.last && fetchRsp.wordIdx == 5'h13 && !fetchBusy)
    else $error("ingress fetch length wrong");
  a_type_check: assert property (take |=> ##1 fetchRsp.typeErr ==
    (fetchRsp.word[3:0] != ($past(fetchReq.egress, 2) ? `XRS_TYPE_EGR : `XRS_TYPE_IGR)))
    else $error("packet type decode wrong");
  a_busy_stream: assert property (fetchBusy && $past(fetchBusy) |-> fetchRsp.valid && !fetchRsp.last)
    else $error("busy without word stream");
  a_word_order: assert property (fetchRsp.valid && !fetchRsp.last
    |=> fetchRsp.valid && fetchRsp.wordIdx == $past(fetchRsp.wordIdx) + 5'h01)
    else $error("record words out of order");
  a_seq_err: assert property (seqError |-> $past(seqUpd.valid) && $past(seqUpd.egress))
    else $error("sequence error without egress update");
endmodule
`default_nettype wire

//--- test/xrs_stage_model.sv
// model of the transform stage that fetches records and writes back sequence
// assumes the bench calls its tasks one at a time
`default_nettype none
module xrs_stage_model
  import xrs_pkg::*;
(
  input wire logic sys_clk,
  output var xrs_fetch_req_t fetchReq,
  output var xrs_seq_upd_t seqUpd,
  input wire xrs_fetch_rsp_t fetchRsp,
  input wire logic fetchBusy,
  input wire logic seqError
);
  timeunit 1ns;
  timeprecision 1ps;
  xrs_word_t rx [0:31];
  int n;
  int errs;
  logic te;
  logic sk;
  logic iv;
  initial begin
    fetchReq = '0;
    seqUpd = '0;
  end
  always @(posedge sys_clk) begin
    if (fetchReq.valid) n <= 0;
    else if (fetchRsp.valid) n <= n + 1;
    if (fetchRsp.valid) rx[fetchRsp.wordIdx] <= fetchRsp.word;
    if (fetchRsp.valid && !fetchRsp.skipped && fetchRsp.wordIdx == 5'h00) te <= fetchRsp.typeErr;
    if (fetchRsp.valid && !fetchRsp.skipped && fetchRsp.wordIdx == 5'h00) iv <= fetchRsp.ivMissing;
    if (fetchRsp.valid) sk <= fetchRsp.skipped;
    errs <= errs + int'(seqError);
  end
  task automatic fetch(input logic [2:0] i, input logic [1:0] a, input logic e);
    int k;
    @(posedge sys_clk);
    fetchReq <= '{1'b1, i, a, e};
    @(posedge sys_clk);
    fetchReq <= {1'b0, ~fetchReq[5:0]};
    for (k = 0; k < 30; k++) begin
      #1;
      if (fetchRsp.valid && fetchRsp.last) break;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #1;
  endtask
  task automatic upd(input logic [2:0] i, input logic e, input logic k, input logic x, input logic [63:0] pn);
    @(posedge sys_clk);
    seqUpd <= '{1'b1, i, e, k, x, pn};
    @(posedge sys_clk);
    seqUpd <= {1'b0, ~seqUpd[69:0]};
    #1;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the transform record store
// assumes the stage model and the checker files are compiled first
`default_nettype none
`include "xrs_cfg.svh"
module tb_top
  import xrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, regWr, regRd, fetchBusy, seqError;
  logic [`XRS_ADDR_W-1:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  xrs_fetch_req_t fetchReq;
  xrs_fetch_rsp_t fetchRsp;
  xrs_seq_upd_t seqUpd;
  int err_total, total_checks, w;
  xrs_record_store DUT (.sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .fetchReq, .fetchRsp, .fetchBusy, .seqUpd, .seqError);
  xrs_stage_model stage (.sys_clk, .fetchReq, .seqUpd, .fetchRsp, .fetchBusy, .seqError);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] pat(input int n, input int w);
    return w == 0 ? 32'h0000_0026 : (w > 12 ? 32'h0000_0000 : 32'h5A00_0000 + 32'(n * 256 + w));
  endfunction
  function automatic logic [11:0] ra(input int n, input int w);
    return 12'(n * 128 + w * 4);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = '0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (w = 0; w < 24; w++) wr(ra(2, w), pat(2, w));
    wr(ra(2, 24), 32'hFFFF_FFFF);
    for (w = 0; w < 25; w++) begin
      rd(ra(2, w));
      chk("record word", d, w < 24 ? pat(2, w) : 32'h0000_0000);
    end
    rd(ra(5, 3));
    chk("other record", d, 32'h0000_0000);
    $display("test registers done");
    stage.fetch(3'h2, `XRS_ACT_MACSEC, 1'b1);
    chk("egress words", stage.n, 32'h0000_0018);
    for (w = 0; w < 24; w++) chk("fetched word", stage.rx[w], pat(2, w));
    chk("egress type flag", stage.te, 32'h0000_0000);
    chk("egress iv flag", stage.iv, 32'h0000_0000);
    stage.fetch(3'h2, `XRS_ACT_MACSEC, 1'b0);
    chk("ingress words", stage.n, 32'h0000_0014);
    chk("ingress type flag", stage.te, 32'h0000_0001);
    wr(`XRS_CTX_CTRL_ADDR, 32'h0000_0001);
    rd(`XRS_CTX_CTRL_ADDR);
    chk("context size", d, 32'h0000_0001);
    stage.fetch(3'h2, `XRS_ACT_MACSEC, 1'b0);
    chk("full size words", stage.n, 32'h0000_0018);
    wr(`XRS_CTX_CTRL_ADDR, 32'h0000_0000);
    for (w = 0; w < 4; w++) begin
      if (w != 2) begin
        stage.fetch(3'h2, 2'(w), 1'b1);
        chk("skipped words", stage.n, 32'h0000_0001);
        chk("skipped flag", stage.sk, 32'h0000_0001);
      end
    end
    wr(ra(2, 0), 32'h0000_001F);
    stage.fetch(3'h2, `XRS_ACT_MACSEC, 1'b0);
    chk("ingress good type", stage.te, 32'h0000_0000);
    chk("iv missing flag", stage.iv, 32'h0000_0001);
    $display("test fetch done");
    stage.upd(3'h2, 1'b1, 1'b0, 1'b0, 64'h0);
    rd(ra(2, 10));
    chk("egress seq", d, pat(2, 10) + 32'h0000_0001);
    rd(ra(2, 11));
    chk("word after seq", d, pat(2, 11));
    wr(ra(2, 10), 32'hFFFF_FFFF);
    stage.upd(3'h2, 1'b1, 1'b0, 1'b0, 64'h0);
    rd(ra(2, 10));
    chk("rollover seq", d, 32'hFFFF_FFFF);
    chk("rollover errors", stage.errs, 32'h0000_0001);
    rd(`XRS_STATUS_ADDR);
    chk("status sticky flags", d, 32'h0000_0006);
    wr(`XRS_STATUS_ADDR, 32'h0000_0006);
    rd(`XRS_STATUS_ADDR);
    chk("status cleared", d, 32'h0000_0000);
    wr(ra(2, 10), 32'h0000_0100);
    stage.upd(3'h2, 1'b0, 1'b0, 1'b0, 64'h80);
    rd(ra(2, 10));
    chk("ingress old pn", d, 32'h0000_0100);
    stage.upd(3'h2, 1'b0, 1'b0, 1'b0, 64'h200);
    rd(ra(2, 10));
    chk("ingress new pn", d, 32'h0000_0201);
    wr(ra(2, 14), 32'hFFFF_FFFF);
    wr(ra(2, 15), 32'h0000_0001);
    stage.upd(3'h2, 1'b1, 1'b1, 1'b1, 64'h0);
    rd(ra(2, 14));
    chk("extended seq low", d, 32'h0000_0000);
    rd(ra(2, 15));
    chk("extended seq high", d, 32'h0000_0002);
    stage.upd(3'h2, 1'b0, 1'b1, 1'b1, 64'h0000_0003_0000_0005);
    rd(ra(2, 14));
    chk("extended ingress low", d, 32'h0000_0006);
    rd(ra(2, 15));
    chk("extended ingress high", d, 32'h0000_0003);
    rd(ra(2, 10));
    chk("plain seq kept", d, 32'h0000_0201);
    $display("test sequence done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule
bind xrs_record_store xrs_store_chk chk (.sys_clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .fetchReq, .fetchRsp, .fetchBusy, .seqUpd, .seqError);
`default_nettype wire
